// ### codec_clk_pkg.sv
package codec_clk_pkg;

    localparam int unsigned CLK_HZ     = 125_000_000;
    localparam int unsigned ADDR_W     = 12;
    localparam int unsigned SYNC_DEPTH = 3;

    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_MODE  = 10'h091;
    localparam logic [9:0] IDX_UPPER = 10'h092;
    localparam logic [9:0] IDX_LOWER = 10'h093;
    localparam logic [9:0] IDX_WHOLE = 10'h094;
    localparam logic [9:0] IDX_FLAGS = 10'h095;
    localparam logic [9:0] IDX_TRIM  = 10'h098;
    localparam logic [9:0] IDX_EVT   = 10'h099;
    localparam logic [9:0] IDX_MASK  = 10'h09A;

    localparam int unsigned MODE_LO  = 6;
    localparam int unsigned SQR_BIT  = 4;
    localparam int unsigned ST_MCLK  = 0;
    localparam int unsigned ST_LOCK  = 3;
    localparam int unsigned ST_ACT   = 4;
    localparam int unsigned ST_TRACK = 7;
    localparam int unsigned CAL_EN   = 7;
    localparam int unsigned CAL_GO   = 6;

    localparam int unsigned EV_W      = 4;
    localparam int unsigned EV_LOCK   = 0;
    localparam int unsigned EV_UNLOCK = 1;
    localparam int unsigned EV_CAL    = 2;
    localparam int unsigned EV_NOCLK  = 3;

    localparam logic [7:0] RST_MODE  = 8'h04;
    localparam logic [4:0] RST_UPPER = 5'h00;
    localparam logic [7:0] RST_LOWER = 8'h00;
    localparam logic [6:0] RST_WHOLE = 7'h20;
    localparam logic [7:0] RST_FLAGS = 8'h00;
    localparam logic [4:0] RST_RES   = 5'h00;
    localparam logic [3:0] RST_EVT   = 4'h0;

    typedef enum logic [1:0] {
        MODE_BYPASS = 2'b00,
        MODE_NORMAL = 2'b01,
        MODE_TRACK  = 2'b10,
        MODE_RSVD   = 2'b11
    } loop_mode_t;

    typedef enum logic [1:0] {
        CAL_IDLE = 2'b01,
        CAL_BUSY = 2'b10
    } cal_state_t;

    typedef struct packed {
        logic [6:0] whole;
        logic [4:0] upper;
        logic [7:0] lower;
    } fbdiv_t;

    // levels from the analog side, asynchronous to clk
    typedef struct packed {
        logic mclk_ok;
        logic loop_lock;
        logic track_lock;
        logic cal_done;
    } ana_in_t;

    typedef struct packed {
        logic       bypass;
        logic       loop_en;
        logic       track_en;
        logic       sqr_en;
        logic [2:0] range;
        fbdiv_t     fbdiv;
        logic       refosc_run;
        logic       cal_en;
        logic       cal_go;
    } clk_ctrl_t;

endpackage

// ### level_sync.sv
`timescale 1ns/1ns
module level_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] level_o
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] level_q;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= async_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // a bit changes only once stages two and three agree
    always_ff @(posedge clk) begin
        if (!nrst) begin
            level_q <= '0;
        end else begin
            level_q <= (s2_q & s3_q) | (level_q & (s2_q ^ s3_q));
        end
    end

    assign level_o = level_q;
endmodule

// ### codec_pll_clock_control.sv
`timescale 1ns/1ns
module codec_pll_clock_control (
    input  wire logic                              clk,
    input  wire logic                              nrst,
    input  wire logic                              psel,
    input  wire logic                              penable,
    input  wire logic                              pwrite,
    input  wire logic [codec_clk_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [31:0]                       pwdata,
    input  wire logic [3:0]                        pstrb,
    output logic      [31:0]                       prdata,
    output logic                                   pready,
    output logic                                   pslverr,
    input  wire codec_clk_pkg::ana_in_t            ana_i,
    input  wire logic [4:0]                        cal_value,
    input  wire logic                              standby,
    output codec_clk_pkg::clk_ctrl_t               ctrl_o,
    output logic                                   irq
);
    import codec_clk_pkg::*;

    logic [9:0]       idx;
    logic             setup;
    logic             access;
    logic             mapped;
    logic             wr;
    logic [7:0]       rd_val;
    logic [31:0]      prdata_q;
    logic [7:0]       mode_q;
    logic [4:0]       upper_q;
    logic [7:0]       lower_q;
    logic [6:0]       whole_q;
    fbdiv_t           fbdiv_q;
    logic             cal_en_q;
    logic             cal_go_q;
    logic [4:0]       cal_res_q;
    cal_state_t       cal_q;
    cal_state_t       cal_d;
    ana_in_t          ana_lvl;
    logic             done_prev_q;
    logic             done_rise;
    logic [7:0]       flags_q;
    logic [7:0]       flags_d;
    logic [EV_W-1:0]  evt_q;
    logic [EV_W-1:0]  evt_set;
    logic [EV_W-1:0]  evt_clr;
    logic [EV_W-1:0]  mask_q;
    logic             go_set;
    logic             cal_finish;
    loop_mode_t       mode;
    clk_ctrl_t        ctrl_q;

    level_sync #(
        .WIDTH   (4)
    ) u_sync (
        .clk     (clk),
        .nrst    (nrst),
        .async_i (ana_i),
        .level_o (ana_lvl)
    );

    assign idx    = paddr[11:2];
    assign setup  = psel & ~penable;
    assign access = psel & penable;
    assign mode   = loop_mode_t'(mode_q[MODE_LO+1:MODE_LO]);

    always_comb begin
        mapped = 1'b1;
        rd_val = 8'h00;
        unique case (idx)
            IDX_MODE:  rd_val = mode_q;
            IDX_UPPER: rd_val = {3'h0, upper_q};
            IDX_LOWER: rd_val = lower_q;
            IDX_WHOLE: rd_val = {1'b0, whole_q};
            IDX_FLAGS: rd_val = flags_q;
            IDX_TRIM:  rd_val = {cal_en_q, cal_go_q, 1'b0, cal_res_q};
            IDX_EVT:   rd_val = {4'h0, evt_q};
            IDX_MASK:  rd_val = {4'h0, mask_q};
            default:   mapped = 1'b0;
        endcase
    end

    // zero wait: read data is captured in the setup cycle
    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;
    assign wr      = access & pwrite & pstrb[0] & mapped;
    assign prdata  = prdata_q;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            prdata_q <= 32'h00000000;
        end else if (setup) begin
            prdata_q <= {24'h000000, rd_val};
        end
    end

    // mode, squarer and range held as written
    always_ff @(posedge clk) begin
        if (!nrst) begin
            mode_q <= RST_MODE;
        end else if (wr && idx == IDX_MODE) begin
            mode_q <= {pwdata[7:6], 1'b0, pwdata[4], 1'b0, pwdata[2:0]};
        end
    end

    // fraction parts staged until the whole part is written
    always_ff @(posedge clk) begin
        if (!nrst) begin
            upper_q <= RST_UPPER;
            lower_q <= RST_LOWER;
        end else if (wr && idx == IDX_UPPER) begin
            upper_q <= pwdata[4:0];
        end else if (wr && idx == IDX_LOWER) begin
            lower_q <= pwdata[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            whole_q <= RST_WHOLE;
            fbdiv_q <= '{whole: RST_WHOLE, upper: RST_UPPER,
                         lower: RST_LOWER};
        end else if (wr && idx == IDX_WHOLE) begin
            whole_q <= pwdata[6:0];
            fbdiv_q <= '{whole: pwdata[6:0], upper: upper_q,
                         lower: lower_q};
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            cal_en_q <= 1'b0;
        end else if (wr && idx == IDX_TRIM) begin
            cal_en_q <= pwdata[CAL_EN];
        end
    end

    // a start request counts only with the block enabled
    assign go_set     = wr && idx == IDX_TRIM && pwdata[CAL_GO]
                        && pwdata[CAL_EN];
    assign done_rise  = ana_lvl.cal_done & ~done_prev_q;
    assign cal_finish = (cal_q == CAL_BUSY) & done_rise;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            done_prev_q <= 1'b0;
        end else begin
            done_prev_q <= ana_lvl.cal_done;
        end
    end

    always_comb begin
        cal_d = cal_q;
        unique case (cal_q)
            CAL_IDLE: begin
                if (cal_go_q && cal_en_q) begin
                    cal_d = CAL_BUSY;
                end
            end
            CAL_BUSY: begin
                if (done_rise || !cal_en_q) begin
                    cal_d = CAL_IDLE;
                end
            end
            default: cal_d = CAL_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            cal_q <= CAL_IDLE;
        end else begin
            cal_q <= cal_d;
        end
    end

    // start bit set by a write of 1, cleared on finish
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cal_go_q <= 1'b0;
        end else if (go_set) begin
            cal_go_q <= 1'b1;
        end else if (cal_finish || !cal_en_q) begin
            cal_go_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            cal_res_q <= RST_RES;
        end else if (cal_finish) begin
            cal_res_q <= cal_value;
        end
    end

    always_comb begin
        flags_d = RST_FLAGS;
        flags_d[ST_MCLK]  = ana_lvl.mclk_ok;
        // loop lock only counts with the loop on
        flags_d[ST_LOCK]  = ana_lvl.loop_lock
                            & (mode == MODE_NORMAL || mode == MODE_TRACK);
        flags_d[ST_ACT]   = (mode == MODE_NORMAL || mode == MODE_TRACK);
        // tracking lock only in tracking mode
        flags_d[ST_TRACK] = ana_lvl.track_lock & (mode == MODE_TRACK);
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            flags_q <= RST_FLAGS;
        end else begin
            flags_q <= flags_d;
        end
    end

    always_comb begin
        evt_set            = RST_EVT;
        evt_set[EV_LOCK]   = flags_d[ST_LOCK] & ~flags_q[ST_LOCK];
        evt_set[EV_UNLOCK] = ~flags_d[ST_LOCK] & flags_q[ST_LOCK];
        evt_set[EV_CAL]    = cal_finish;
        evt_set[EV_NOCLK]  = ~flags_d[ST_MCLK] & flags_q[ST_MCLK];
    end

    // only bits actually returned are cleared, so a late event survives
    assign evt_clr = (access && !pwrite && idx == IDX_EVT)
                     ? prdata_q[EV_W-1:0] : RST_EVT;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            evt_q <= RST_EVT;
        end else begin
            evt_q <= (evt_q & ~evt_clr) | evt_set;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            mask_q <= RST_EVT;
        end else if (wr && idx == IDX_MASK) begin
            mask_q <= pwdata[EV_W-1:0];
        end
    end

    assign irq = |(evt_q & mask_q);

    // mode decode; reserved code keeps the loop off
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ctrl_q <= '0;
        end else begin
            ctrl_q.bypass   <= (mode == MODE_BYPASS || mode == MODE_RSVD);
            ctrl_q.loop_en  <= (mode == MODE_NORMAL || mode == MODE_TRACK);
            ctrl_q.track_en <= (mode == MODE_TRACK);
            ctrl_q.sqr_en   <= mode_q[SQR_BIT];
            ctrl_q.range    <= mode_q[2:0];
            ctrl_q.fbdiv    <= fbdiv_q;
            // oscillator runs without a clock unless in standby
            ctrl_q.refosc_run <= ~ana_lvl.mclk_ok & ~standby;
            ctrl_q.cal_en   <= cal_en_q;
            ctrl_q.cal_go   <= (cal_q == CAL_BUSY);
        end
    end

    assign ctrl_o = ctrl_q;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    a_bypass_mode: assert property (
        wr && idx == IDX_MODE && pwdata[7:6] == 2'b00
        |-> ##2 ctrl_q.bypass && !ctrl_q.loop_en)
        else $error("bypass mode did not stop the loop");

    a_normal_mode: assert property (
        wr && idx == IDX_MODE && pwdata[7:6] == 2'b01
        |-> ##2 ctrl_q.loop_en && !ctrl_q.track_en && !ctrl_q.bypass)
        else $error("normal mode did not enable the loop");

    a_track_mode: assert property (
        wr && idx == IDX_MODE && pwdata[7:6] == 2'b10
        |-> ##2 ctrl_q.loop_en && ctrl_q.track_en)
        else $error("tracking mode not entered");

    a_squarer_bit: assert property (
        wr && idx == IDX_MODE
        |-> ##2 ctrl_q.sqr_en == $past(pwdata[SQR_BIT], 2))
        else $error("squarer enable does not follow write");

    a_divisor_commit: assert property (
        wr && idx == IDX_WHOLE
        |=> fbdiv_q == {$past(pwdata[6:0]), upper_q, lower_q})
        else $error("divisor not committed on whole write");

    a_fraction_staged: assert property (
        wr && (idx == IDX_UPPER || idx == IDX_LOWER)
        |=> $stable(fbdiv_q))
        else $error("fraction write changed active divisor");

    a_unused_zero: assert property (
        setup && idx == IDX_FLAGS
        |=> prdata_q[2:1] == 2'b00 && prdata_q[6:5] == 2'b00)
        else $error("unused status bits read nonzero");

    a_lock_gated: assert property (
        flags_q[ST_LOCK] |-> $past(mode_q[7:6]) != 2'b00)
        else $error("lock reported with loop bypassed");

    a_status_ro: assert property (
        wr && idx == IDX_FLAGS |=> flags_q == $past(flags_d))
        else $error("status write had an effect");

    a_osc_run: assert property (
        $fell(ana_lvl.mclk_ok) && !standby ##1 !standby
        |-> ctrl_q.refosc_run)
        else $error("oscillator not running without clock");

    a_go_clears: assert property (
        cal_finish && !go_set |=> !cal_go_q ##1 ctrl_q.cal_go == 1'b0)
        else $error("start bit did not clear on finish");

    a_result_load: assert property (
        cal_finish |=> cal_res_q == $past(cal_value))
        else $error("calibration result not captured");

    a_go_start: assert property (
        go_set && cal_q == CAL_IDLE |=> cal_go_q ##1 cal_q == CAL_BUSY)
        else $error("write of one did not start calibration");

    c_track_lock: cover property (
        mode == MODE_TRACK && flags_q[ST_TRACK]);
    c_cal_cycle: cover property (cal_finish);
    c_irq_raise: cover property ($rose(irq));
    c_evt_race: cover property (|(evt_clr & evt_set));
endmodule

// ### clk_source_model.sv
`timescale 1ns/1ns
module clk_source_model (
    input  wire logic                     clk,
    input  wire logic                     nrst,
    input  wire codec_clk_pkg::clk_ctrl_t ctrl,
    input  wire logic                     mclk_on,
    input  wire logic                     slow,
    output codec_clk_pkg::ana_in_t        ana,
    output logic [4:0]                    cal_val
);
    import codec_clk_pkg::*;
    parameter logic [4:0] CAL_RESULT = 5'h16;

    int unsigned lock_q;
    int unsigned cal_q;
    int unsigned dly;

    assign dly = slow ? 40 : 3;

    // lock needs a running input clock for a while
    always @(posedge clk) begin
        if (!nrst || !mclk_on || !(ctrl.loop_en || ctrl.track_en)) begin
            lock_q <= 0;
        end else if (lock_q < 60) begin
            lock_q <= lock_q + 1;
        end
    end

    always @(posedge clk) begin
        if (!nrst || !ctrl.cal_go) begin
            cal_q <= 0;
        end else if (cal_q < 60) begin
            cal_q <= cal_q + 1;
        end
    end

    assign ana.mclk_ok    = mclk_on;
    assign ana.loop_lock  = ctrl.loop_en && (lock_q >= dly);
    assign ana.track_lock = ctrl.track_en && (lock_q >= dly);
    assign ana.cal_done   = ctrl.cal_go && (cal_q >= dly);
    // result valid only while done is high, so a late capture shows up
    assign cal_val = ana.cal_done ? CAL_RESULT : ~cal_q[4:0];
endmodule

// ### tb.sv
`timescale 1ns/1ns
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
    $display("unexpected at %0t: got %0h expected %0h", $time, g, e); end end
module tb;
    import codec_clk_pkg::*;
    localparam logic [4:0] CAL_RESULT = 5'h16;

    logic                clk;
    logic                nrst;
    logic                psel;
    logic                penable;
    logic                pwrite;
    logic [ADDR_W-1:0]   paddr;
    logic [31:0]         pwdata;
    logic [3:0]          pstrb;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    logic [31:0]         rd;
    logic                err;
    logic                mclk_on;
    logic                slow;
    logic                standby;
    logic                irq;
    logic [4:0]          cal_val;
    logic [2:0]          m;
    logic [31:0]         v;
    ana_in_t             ana;
    clk_ctrl_t           ctrl;
    int                  err_count;
    int                  checked;

    codec_pll_clock_control codec_pll_clock_control_inst (
        .clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .ana_i(ana),
        .cal_value(cal_val), .standby(standby), .ctrl_o(ctrl), .irq(irq)
    );

    clk_source_model #(.CAL_RESULT(CAL_RESULT)) clk_source_model_inst (
        .clk(clk), .nrst(nrst), .ctrl(ctrl), .mclk_on(mclk_on),
        .slow(slow), .ana(ana), .cal_val(cal_val)
    );

    initial clk = 1'b0;
    always #4 clk = ~clk;

    task automatic wrap_up;
        if (err_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [9:0] idx,
                       input logic [31:0] wd);
        int i;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            err_count++;
            wrap_up();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] idx, input logic [31:0] wd);
        apb(1'b1, idx, wd);
    endtask

    task automatic chk_rd(input logic [9:0] idx, input logic [31:0] e);
        apb(1'b0, idx, 32'h0);
        `CHK(rd, e)
    endtask

    // polls a register until the masked value matches, bounded
    task automatic poll(input logic [9:0] idx, input logic [31:0] mask,
                        input logic [31:0] e);
        int i;
        for (i = 0; i < 60; i++) begin
            apb(1'b0, idx, 32'h0);
            if ((rd & mask) === e) break;
        end
        `CHK(rd & mask, e)
    endtask

    initial begin
        nrst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = '0; pwdata = 32'h0; pstrb = 4'hF;
        mclk_on = 1'b0; slow = 1'b0; standby = 1'b0;
        err_count = 0; checked = 0;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        chk_rd(IDX_MODE, 32'h04);
        chk_rd(IDX_UPPER, 32'h00);
        chk_rd(IDX_LOWER, 32'h00);
        chk_rd(IDX_WHOLE, 32'h20);
        chk_rd(IDX_FLAGS, 32'h00);
        chk_rd(IDX_TRIM, 32'h00);
        `CHK({ctrl.bypass, ctrl.range}, 4'hC)
        `CHK(ctrl.refosc_run, 1'b1)
        standby <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK(ctrl.refosc_run, 1'b0)
        standby <= 1'b0;
        mclk_on <= 1'b1;
        poll(IDX_FLAGS, 32'h01, 32'h01);
        repeat (3) @(posedge clk);
        `CHK(ctrl.refosc_run, 1'b0)
        for (m = 0; m < 4; m++) begin
            v = {24'h0, m[1:0], 1'b0, m[0], 1'b0, m};
            wr(IDX_MODE, v);                 // range codes stay 0-3
            chk_rd(IDX_MODE, v);
            repeat (3) @(posedge clk);
            `CHK(ctrl.bypass, m == 0 || m == 3)
            `CHK(ctrl.sqr_en, m[0])
            `CHK(ctrl.range, m)
            if (m == 1) `CHK(ctrl.loop_en, 1'b1)
            if (m == 2) `CHK(ctrl.track_en, 1'b1)
            if (m == 0 || m == 3) `CHK({ctrl.loop_en, ctrl.track_en}, 2'b00)
        end
        apb(1'b0, IDX_EVT, 32'h0);
        wr(IDX_MASK, 32'h0);
        wr(IDX_MODE, 32'h44);
        poll(IDX_FLAGS, 32'hFF, 32'h19);
        `CHK(irq, 1'b0)
        wr(IDX_MASK, 32'h1);
        @(posedge clk);
        `CHK(irq, 1'b1)
        apb(1'b0, IDX_EVT, 32'h0);
        `CHK(rd[0], 1'b1)
        @(posedge clk);
        `CHK(irq, 1'b0)
        wr(IDX_FLAGS, 32'hFF);
        chk_rd(IDX_FLAGS, 32'h19);
        wr(IDX_MODE, 32'h84);
        poll(IDX_FLAGS, 32'hF7, 32'h91);
        wr(IDX_MODE, 32'h04);
        poll(IDX_FLAGS, 32'hFF, 32'h01);
        wr(IDX_UPPER, 32'hFF);
        wr(IDX_LOWER, 32'hA5);
        repeat (3) @(posedge clk);
        `CHK(ctrl.fbdiv, {7'h20, 5'h00, 8'h00})
        chk_rd(IDX_UPPER, 32'h1F);
        wr(IDX_WHOLE, 32'hB3);
        repeat (3) @(posedge clk);
        `CHK(ctrl.fbdiv, {7'h33, 5'h1F, 8'hA5})
        chk_rd(IDX_WHOLE, 32'h33);
        pstrb <= 4'h0;
        wr(IDX_LOWER, 32'h00);
        pstrb <= 4'hF;
        chk_rd(IDX_LOWER, 32'hA5);
        apb(1'b1, 10'h0FF, 32'h12);
        `CHK(err, 1'b1)
        apb(1'b0, 10'h0FF, 32'h0);
        `CHK({err, rd}, {1'b1, 32'h0})
        apb(1'b0, IDX_EVT, 32'h0);
        wr(IDX_MASK, 32'h4);
        wr(IDX_TRIM, 32'h40);
        repeat (4) @(posedge clk);
        `CHK(ctrl.cal_go, 1'b0)
        wr(IDX_TRIM, 32'h9F);
        chk_rd(IDX_TRIM, 32'h80);
        repeat (3) @(posedge clk);
        `CHK(ctrl.cal_en, 1'b1)
        slow <= 1'b1;
        wr(IDX_TRIM, 32'hC0);
        repeat (4) @(posedge clk);
        `CHK(ctrl.cal_go, 1'b1)
        poll(IDX_TRIM, 32'hFF, {24'h0, 3'b100, CAL_RESULT});
        `CHK(irq, 1'b1)
        apb(1'b0, IDX_EVT, 32'h0);
        `CHK(rd[2], 1'b1)
        slow <= 1'b0;
        repeat (8) @(posedge clk);
        wr(IDX_TRIM, 32'hC0);
        chk_rd(IDX_TRIM, {24'h0, 3'b110, CAL_RESULT});
        poll(IDX_TRIM, 32'hFF, {24'h0, 3'b100, CAL_RESULT});
        wr(IDX_TRIM, 32'h80);
        repeat (4) @(posedge clk);
        `CHK(ctrl.cal_go, 1'b0)
        mclk_on <= 1'b0;
        poll(IDX_FLAGS, 32'h01, 32'h00);
        repeat (3) @(posedge clk);
        `CHK(ctrl.refosc_run, 1'b1)
        wrap_up();
    end
endmodule
